// File: inc/sbcr_defs.svh
/*
 * Offsets, field positions, reset values and widths of the base configuration registers.
 * Assumes a single-clock register port with byte-wide data and byte addresses.
 */
`ifndef SBCR_DEFS_SVH
`define SBCR_DEFS_SVH

`define SBCR_OFS_TARGET_ADDR     8'h00
`define SBCR_OFS_RESET_CTRL      8'h01
`define SBCR_OFS_GENERAL_CFG     8'h02
`define SBCR_OFS_OPER_SEL        8'h03

`define SBCR_BIT_ADDR_OVR        0
`define SBCR_BIT_ROM_RELOAD      2
`define SBCR_BIT_FULL_RESET      1
`define SBCR_BIT_CORE_RESET      0
`define SBCR_BIT_CLK_CONT        6
`define SBCR_BIT_CRC_EN          1
`define SBCR_BIT_VOLT_18         0
`define SBCR_BIT_MODE_OVR        4
`define SBCR_BIT_MODE_DONE       3

`define SBCR_RST_LANES           2'h3
`define SBCR_RST_CRC_EN          1'h1
`define SBCR_RST_MODE_DONE       1'h0
`define SBCR_READ_UNMAPPED       8'h00
`define SBCR_STRAP_SETTLE        2'h2

`endif

// File: inc/sbcr_pkg.sv
/*
 * Types of the base configuration register block.
 * Assumes sbcr_defs.svh supplies the numeric constants.
 */
package sbcr_pkg;

	typedef enum logic [2:0] {
		SBCR_MODE_SYNC_CAMERA = 3'h0,
		SBCR_MODE_RESERVED    = 3'h1,
		SBCR_MODE_NONSYNC_EXT = 3'h2,
		SBCR_MODE_NONSYNC_AON = 3'h3,
		SBCR_MODE_PARALLEL    = 3'h5
	} sbcr_mode_t;

	typedef struct packed {
		logic [6:0] target_address;
		logic [6:0] mode_pin;
		logic       bus_volt_18;
		logic       power_down_n;
	} sbcr_pins_t;

	typedef struct packed {
		logic [6:0] i2c_target_address;
		logic       clock_lane_continuous;
		logic [1:0] data_lane_count;
		logic       crc_tx_enable;
		logic       bus_volt_18;
		logic [2:0] operating_mode;
		logic       mode_latched;
	} sbcr_cfg_t;

	typedef struct packed {
		logic [6:0] addr;
		logic       addr_ovr;
		logic [4:0] rst_spare;
		logic       rom_reload;
		logic       full_reset;
		logic       core_reset;
		logic       gcfg_spare7;
		logic       clk_cont;
		logic [1:0] lanes;
		logic [1:0] gcfg_spare;
		logic       crc_en;
		logic       volt_18;
		logic       oper_spare7;
		logic       oper_spare5;
		logic       mode_ovr;
		logic       mode_done;
		logic [2:0] mode;
		logic       straps_loaded;
		logic       pdn_prev;
		logic [7:0] rdata;
		logic       rd_valid;
	} sbcr_regs_t;

endpackage

// File: design/sbcr_base_config_regs.sv
/*
 * Base configuration registers of a camera-link serializer: target address, reset requests,
 * camera lane setup, transmit CRC enable, bus voltage level and operating mode.
 * Assumes a register port on the device clock driven by the bus engine, strap pins and the
 * power-down pin arriving asynchronously, and i_rst_n as the power-on reset.
 * Fields that a host may not change read back what the device is using, so one read always
 * shows the state in effect.
 * The reset requests and the ROM reload request leave as one-cycle pulses; apart from these registers, which the
 * full reset restores, the logic that they reset or restart lies outside this block.
 * Assumes that the bus engine presents each access as a one-cycle strobe and copes with the read
 * answer arriving one cycle later, and that straps are stable while the device runs.
 * Assumes that nothing else drives the same offsets.
 */
// Functional notes
// - Address field reads the address in use.
// - Address override off: read-only strap; on: writable.
// - ROM reload request pulses, then self-clears.
// - Full reset clears logic and registers, self-clears.
// - Core reset clears logic, keeps registers, self-clears.
// - Clock lane bit selects continuous clock.
// - Lane count 00/01/11 gives 1/2/4 lanes.
// - Transmit CRC enable, reset value on.
// - Voltage bit strap-loaded, writable, 1 is 1.8 V.
// - Mode override picks strap or register mode.
// - Mode latched flag set once mode captured.
// - Mode field shows mode, writable under override.
// - Strapped mode captured on power-down pin rise.
// - Mode codes 000, 010, 011, 101 defined.
// - Strap fields load from pins at start-up.
`timescale 1ns/1ns
`include "sbcr_defs.svh"

module sbcr_base_config_regs
	import sbcr_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_reg_wr_en,
	input  wire logic       i_reg_rd_en,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire sbcr_pins_t i_pins,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_rd_valid,
	output sbcr_cfg_t       o_cfg,
	output logic            o_rom_reload,
	output logic            o_logic_reset,
	output logic            o_config_reset
);

	logic       rst_meta_n;
	logic       rst_sync_n;
	sbcr_pins_t pins_meta;
	sbcr_pins_t pins_sync;
	sbcr_regs_t regs;
	sbcr_regs_t next_regs;
	sbcr_regs_t reg_defaults;
	logic       pdn_rise;
	logic [7:0] rd_word;
	logic [1:0] strap_wait;
	logic [1:0] next_strap_wait;
	logic       straps_ready;
	logic       sel_target;
	logic       sel_reset;
	logic       sel_general;
	logic       sel_oper;

	// Reset release is synchronised; assertion stays asynchronous.
	// Without this, flops leaving reset on different edges could load a half-reset register file.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// Straps and the power-down pin are asynchronous to the device clock.
	// Straps are static in use, so two flops per bit are enough without a handshake.
	always_ff @(posedge i_sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pins_meta <= '0;
			pins_sync <= '0;
		end else begin
			pins_meta <= i_pins;
			pins_sync <= pins_meta;
		end
	end

	// The synchroniser holds zeros for two edges after reset, so strap loading waits for real pin levels.
	// A full reset reuses the settled synchroniser, so straps reload on the next edge.
	always_comb begin
		next_strap_wait = strap_wait;
		if (strap_wait != `SBCR_STRAP_SETTLE) begin
			next_strap_wait = strap_wait + 2'h1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			strap_wait <= 2'h0;
		end else begin
			strap_wait <= next_strap_wait;
		end
	end

	assign straps_ready = (strap_wait == `SBCR_STRAP_SETTLE);

	always_comb begin
		// Every field is listed so that a new field cannot silently miss its reset value.
		reg_defaults.addr          = 7'h00;
		reg_defaults.addr_ovr      = 1'h0;
		reg_defaults.rst_spare     = 5'h00;
		reg_defaults.rom_reload    = 1'h0;
		reg_defaults.full_reset    = 1'h0;
		reg_defaults.core_reset    = 1'h0;
		reg_defaults.gcfg_spare7   = 1'h0;
		reg_defaults.clk_cont      = 1'h0;
		reg_defaults.lanes         = `SBCR_RST_LANES;
		reg_defaults.gcfg_spare    = 2'h0;
		reg_defaults.crc_en        = `SBCR_RST_CRC_EN;
		reg_defaults.volt_18       = 1'h0;
		reg_defaults.oper_spare7   = 1'h0;
		reg_defaults.oper_spare5   = 1'h0;
		reg_defaults.mode_ovr      = 1'h0;
		reg_defaults.mode_done     = `SBCR_RST_MODE_DONE;
		reg_defaults.mode          = 3'h0;
		reg_defaults.straps_loaded = 1'h0;
		reg_defaults.pdn_prev      = 1'h0;
		reg_defaults.rdata         = 8'h00;
		reg_defaults.rd_valid      = 1'h0;
	end

	// The previous pin level resets low, so a pin already high at start-up still latches.
	// It also relatches after a full reset, because the previous level resets low there too.
	assign pdn_rise = pins_sync.power_down_n && !regs.pdn_prev;

	// One decode of the offset serves the read mux.
	// The offsets are exclusive, so at most one select is high.
	assign sel_target  = (i_reg_addr == `SBCR_OFS_TARGET_ADDR);
	assign sel_reset   = (i_reg_addr == `SBCR_OFS_RESET_CTRL);
	assign sel_general = (i_reg_addr == `SBCR_OFS_GENERAL_CFG);
	assign sel_oper    = (i_reg_addr == `SBCR_OFS_OPER_SEL);

	always_comb begin
		// Unmapped offsets read zero so that a probing host sees no stale data.
		rd_word = `SBCR_READ_UNMAPPED;
		if (sel_target) begin
			rd_word[7:1] = regs.addr;
			rd_word[0]   = regs.addr_ovr;
		end
		// Request bits read one only in the cycle that follows their write.
		if (sel_reset) begin
			rd_word[7:3] = regs.rst_spare;
			rd_word[2]   = regs.rom_reload;
			rd_word[1]   = regs.full_reset;
			rd_word[0]   = regs.core_reset;
		end
		if (sel_general) begin
			rd_word[7]   = regs.gcfg_spare7;
			rd_word[6]   = regs.clk_cont;
			rd_word[5:4] = regs.lanes;
			rd_word[3:2] = regs.gcfg_spare;
			rd_word[1]   = regs.crc_en;
			rd_word[0]   = regs.volt_18;
		end
		if (sel_oper) begin
			// The strap-status bit is reserved and reads as zero.
			rd_word[7]   = regs.oper_spare7;
			rd_word[6]   = 1'b0;
			rd_word[5]   = regs.oper_spare5;
			rd_word[4]   = regs.mode_ovr;
			rd_word[3]   = regs.mode_done;
			rd_word[2:0] = regs.mode;
		end
	end

	always_comb begin
		next_regs            = regs;
		// Self-clearing requests last exactly one cycle unless written again.
		next_regs.rom_reload = 1'b0;
		next_regs.full_reset = 1'b0;
		next_regs.core_reset = 1'b0;
		next_regs.rd_valid   = i_reg_rd_en;
		next_regs.pdn_prev   = pins_sync.power_down_n;

		// Read data is captured at the request edge and held until the next read.
		if (i_reg_rd_en) begin
			next_regs.rdata = rd_word;
		end

		// The voltage takes the pins once after power-on reset and each full reset, the address each cycle without override; a core reset does not reload them.
		// Loading waits for the synchroniser, or the voltage level would latch its reset zero.
		if (!regs.straps_loaded && straps_ready) begin
			next_regs.straps_loaded = 1'b1;
			next_regs.addr          = pins_sync.target_address;
			next_regs.volt_18       = pins_sync.bus_volt_18;
		end

		// Without override the stored address follows the straps, so turning override on loads the value from that write.
		if (!regs.addr_ovr) begin
			next_regs.addr = pins_sync.target_address;
		end

		// The latched flag stays set until a full reset; the pin going low again does not clear it.
		if (pdn_rise) begin
			next_regs.mode_done = 1'b1;
			if (!regs.mode_ovr) begin
				next_regs.mode = pins_sync.mode_pin[2:0];
			end
		end

		if (i_reg_wr_en) begin
			unique case (i_reg_addr)
				// Setting the override in the same write loads the address from that write.
				`SBCR_OFS_TARGET_ADDR: begin
					next_regs.addr_ovr = i_reg_wdata[`SBCR_BIT_ADDR_OVR];
					if (i_reg_wdata[`SBCR_BIT_ADDR_OVR]) begin
						next_regs.addr = i_reg_wdata[7:1];
					end
				end
				// A write of one wins over the self-clear, except in the cycle of a full reset request, where the defaults win.
				`SBCR_OFS_RESET_CTRL: begin
					next_regs.rst_spare  = i_reg_wdata[7:3];
					next_regs.rom_reload = i_reg_wdata[`SBCR_BIT_ROM_RELOAD];
					next_regs.full_reset = i_reg_wdata[`SBCR_BIT_FULL_RESET];
					next_regs.core_reset = i_reg_wdata[`SBCR_BIT_CORE_RESET];
				end
				`SBCR_OFS_GENERAL_CFG: begin
					next_regs.gcfg_spare7 = i_reg_wdata[7];
					next_regs.clk_cont    = i_reg_wdata[`SBCR_BIT_CLK_CONT];
					// Code 10 is stored as written; downstream treats it as reserved.
					next_regs.lanes       = i_reg_wdata[5:4];
					next_regs.gcfg_spare  = i_reg_wdata[3:2];
					next_regs.crc_en      = i_reg_wdata[`SBCR_BIT_CRC_EN];
					// Local writes are accepted too; only the host knows whether it came over the back channel.
					next_regs.volt_18     = i_reg_wdata[`SBCR_BIT_VOLT_18];
				end
				// Mode codes are stored unchecked; the reserved code only matters to the mode decoder.
				`SBCR_OFS_OPER_SEL: begin
					next_regs.oper_spare7 = i_reg_wdata[7];
					next_regs.oper_spare5 = i_reg_wdata[5];
					next_regs.mode_ovr    = i_reg_wdata[`SBCR_BIT_MODE_OVR];
					if (i_reg_wdata[`SBCR_BIT_MODE_OVR]) begin
						next_regs.mode = i_reg_wdata[2:0];
					end
				end
				default: begin
				end
			endcase
		end

		// A full reset request restores defaults, then straps reload and the mode relatches.
		// A read in that same cycle is still answered, so the host never waits on a lost reply.
		if (regs.full_reset) begin
			next_regs          = reg_defaults;
			next_regs.rd_valid = i_reg_rd_en;
			next_regs.rdata    = i_reg_rd_en ? rd_word : regs.rdata;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// This literal must match reg_defaults; only the synchronised reset uses it.
			regs <= '{
				lanes:   `SBCR_RST_LANES,
				crc_en:  `SBCR_RST_CRC_EN,
				default: '0
			};
		end else begin
			regs <= next_regs;
		end
	end

	// Configuration levels and read data seen by the rest of the device.
	assign o_reg_rdata                     = regs.rdata;
	assign o_reg_rd_valid                  = regs.rd_valid;
	assign o_cfg.i2c_target_address        = regs.addr;
	assign o_cfg.clock_lane_continuous     = regs.clk_cont;
	assign o_cfg.data_lane_count           = regs.lanes;
	assign o_cfg.crc_tx_enable             = regs.crc_en;
	assign o_cfg.bus_volt_18               = regs.volt_18;
	assign o_cfg.operating_mode            = regs.mode;
	assign o_cfg.mode_latched              = regs.mode_done;

	// Single-cycle reset and reload requests.
	assign o_rom_reload                    = regs.rom_reload;
	assign o_logic_reset                   = regs.core_reset | regs.full_reset;
	assign o_config_reset                  = regs.full_reset;

endmodule

// File: tb/sbcr_regs_asserts.sv
/* Port checker of the base configuration registers.
   Assumes the bind at the foot attaches it to the register block. */
`timescale 1ns/1ns
module sbcr_regs_asserts
	import sbcr_pkg::*;
(
	input wire logic       i_sys_clk,
	input wire logic       i_rst_n,
	input wire logic       i_reg_wr_en,
	input wire logic       i_reg_rd_en,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       o_reg_rd_valid,
	input wire sbcr_cfg_t  o_cfg,
	input wire logic       o_rom_reload,
	input wire logic       o_logic_reset,
	input wire logic       o_config_reset
);
	logic wr1;
	logic wr2;
	logic wr3;
	assign wr1 = i_reg_wr_en && i_reg_addr == 8'h01 && !o_config_reset;
	assign wr2 = i_reg_wr_en && i_reg_addr == 8'h02 && !o_config_reset;
	assign wr3 = i_reg_wr_en && i_reg_addr == 8'h03 && !o_config_reset;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	rd_answer_a: assert property (i_reg_rd_en |=> o_reg_rd_valid) else $error("read not answered");
	rom_pulse_a: assert property (wr1 && i_reg_wdata[2] |=> o_rom_reload) else $error("no reload");
	rom_clear_a: assert property (o_rom_reload |=> !o_rom_reload) else $error("reload stuck");
	full_rst_a: assert property (wr1 && i_reg_wdata[1] |=> o_config_reset && o_logic_reset)
		else $error("no full reset");
	core_keep_a: assert property (wr1 && i_reg_wdata[1:0] == 2'h1 |=> o_logic_reset && !o_config_reset)
		else $error("core reset wrong");
	cfg_reload_a: assert property (o_config_reset |=> o_cfg.data_lane_count == 2'h3 && o_cfg.crc_tx_enable)
		else $error("config not reset");
	clk_lane_a: assert property (wr2 |=> o_cfg.clock_lane_continuous == $past(i_reg_wdata[6]))
		else $error("clock lane wrong");
	lane_count_a: assert property (wr2 |=> o_cfg.data_lane_count == $past(i_reg_wdata[5:4]))
		else $error("lane count wrong");
	mode_write_a: assert property (wr3 && i_reg_wdata[4] |=> o_cfg.operating_mode == $past(i_reg_wdata[2:0]))
		else $error("mode write lost");
endmodule

bind sbcr_base_config_regs sbcr_regs_asserts u_chk (.i_sys_clk, .i_rst_n, .i_reg_wr_en, .i_reg_rd_en,
	.i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rd_valid, .o_cfg, .o_rom_reload, .o_logic_reset,
	.o_config_reset);

// File: tb/sbcr_host_model.sv
/* Register host model: one byte access at a time, driven at the falling edge.
   Assumes the read answer is registered at the request edge and sampled at the next falling edge. */
`timescale 1ns/1ns
module sbcr_host_model (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rd_valid,
	input  wire logic [7:0] i_rdata,
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wdata
);
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// Released address and data are inverted and the enables drop, so a stale value is never mistaken for a request.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge i_sys_clk);
		o_addr = a;
		o_wdata = d;
		o_wr_en = w;
		o_rd_en = !w;
		@(negedge i_sys_clk);
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
		q = (i_rd_valid === 1'b1) ? i_rdata : 8'hXX;
	endtask
endmodule

// File: tb/tb_sbcr_base_config_regs.sv
/* Testbench of the base configuration registers.
   Assumes the host model drives the register port and the bench drives the pins. */
`timescale 1ns/1ns
module tb_sbcr_base_config_regs;
	import sbcr_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	sbcr_pins_t pins = {7'h2A, 7'h02, 1'b1, 1'b1};
	logic       wr_en, rd_en, rd_valid, rom, lrst, crst;
	logic [7:0] addr, wdata, rdata, d;
	sbcr_cfg_t  cfg;
	int         err_count = 0;
	int         checked = 0;
	always #2 clk = ~clk;
	sbcr_base_config_regs dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr_en(wr_en), .i_reg_rd_en(rd_en),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_pins(pins), .o_reg_rdata(rdata), .o_reg_rd_valid(rd_valid),
		.o_cfg(cfg), .o_rom_reload(rom), .o_logic_reset(lrst), .o_config_reset(crst));
	sbcr_host_model host (.i_sys_clk(clk), .i_rd_valid(rd_valid), .i_rdata(rdata), .o_wr_en(wr_en),
		.o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		logic [7:0] q;
		host.acc(1'b1, a, v, q);
	endtask
	task automatic rd(logic [7:0] a);
		host.acc(1'b0, a, 8'h00, d);
	endtask
	task automatic t_start;
		rd(8'h00);
		chk("addr", d, 8'h54);
		rd(8'h02);
		chk("gcfg", d, 8'h33);
		rd(8'h03);
		chk("mode", d, 8'h0A);
		chk("cfg out", {cfg.clock_lane_continuous, cfg.crc_tx_enable, cfg.bus_volt_18, cfg.mode_latched, 1'b0, cfg.operating_mode}, 8'h72);
		rd(8'h07);
		chk("unmapped", d, 8'h00);
	endtask
	task automatic t_addr;
		wr(8'h00, 8'h5C);
		rd(8'h00);
		chk("addr ro", d, 8'h54);
		wr(8'h00, 8'h67);
		chk("addr cfg", {1'b0, cfg.i2c_target_address}, 8'h33);
		rd(8'h00);
		chk("addr rw", d, 8'h67);
	endtask
	task automatic t_cfg;
		logic [1:0] ln [3] = '{2'h0, 2'h1, 2'h3};
		logic [7:0] v;
		// Lane code 10 is never used, and bit 0 keeps the strapped level.
		foreach (ln[i]) begin
			v = {1'b0, i[0], ln[i], 2'h0, ~i[0], 1'b1};
			wr(8'h02, v);
			chk("lanes", {6'h0, cfg.data_lane_count}, {6'h0, ln[i]});
			rd(8'h02);
			chk("gcfg rw", d, v);
		end
	endtask
	task automatic t_mode;
		logic [2:0] mc [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
		foreach (mc[i]) begin
			wr(8'h03, {5'h02, mc[i]});
			rd(8'h03);
			chk("mode code", d, {5'h03, mc[i]});
		end
		wr(8'h03, 8'h00);
		pins.mode_pin = 7'h03;
		pins.power_down_n = 1'b0;
		repeat (6) @(negedge clk);
		pins.power_down_n = 1'b1;
		repeat (6) @(negedge clk);
		rd(8'h03);
		chk("mode pin", d, 8'h0B);
	endtask
	task automatic t_rst;
		wr(8'h01, 8'h04);
		chk("reload", {7'h0, rom}, 8'h01);
		@(negedge clk);
		chk("reload clr", {7'h0, rom}, 8'h00);
		wr(8'h01, 8'h01);
		chk("core rst", {6'h0, crst, lrst}, 8'h01);
		rd(8'h00);
		chk("addr kept", d, 8'h67);
		wr(8'h01, 8'h02);
		chk("full rst", {6'h0, crst, lrst}, 8'h03);
		repeat (8) @(negedge clk);
		rd(8'h00);
		chk("addr back", d, 8'h54);
		rd(8'h02);
		chk("gcfg back", d, 8'h33);
		rd(8'h01);
		chk("rst clr", d, 8'h00);
	endtask
	task automatic summarize;
		$display("TB: checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		t_start;
		t_addr;
		t_cfg;
		t_mode;
		t_rst;
		summarize;
	end
	initial begin
		repeat (5000) @(negedge clk);
		err_count++;
		summarize;
	end
endmodule
